// *** shared/cpsc_pkg.sv ***
// Constants, field positions and types of the converter control and status block.
package cpsc_pkg;

   // ==========================================================
   // Register byte offsets within the converter window.
   localparam logic [7:0] ADDR_CVSD_IN  = 8'h20;
   localparam logic [7:0] ADDR_CVSD_OUT = 8'h22;
   localparam logic [7:0] ADDR_PCM_IN   = 8'h24;
   localparam logic [7:0] ADDR_PCM_OUT  = 8'h26;
   localparam logic [7:0] ADDR_CTRL     = 8'h30;
   localparam logic [7:0] ADDR_STAT     = 8'h32;

   // ==========================================================
   // Control word layout and reset value.
   localparam int unsigned  CB_ENABLE  = 0;
   localparam int unsigned  CB_CLKEN   = 1;
   localparam int unsigned  CB_PCM_IRQ = 2;
   localparam int unsigned  CB_LVL_IRQ = 3;
   localparam int unsigned  CB_ERR_IRQ = 4;
   localparam int unsigned  CB_PCM_OUT_DMA  = 5;
   localparam int unsigned  CB_CVSD_OUT_DMA = 6;
   localparam int unsigned  CB_CVSD_IN_DMA  = 7;
   localparam int unsigned  CB_PCM_IN_DMA   = 8;
   localparam int unsigned  CB_FMT     = 10;
   localparam int unsigned  CB_CMP     = 12;
   localparam int unsigned  CB_ATT     = 13;
   localparam logic [15:0]  CTRL_RESET = 16'h0000;
   localparam logic [15:0]  CTRL_MASK  = 16'h7DFF;

   // ==========================================================
   // Status word layout and reset value.
   localparam int unsigned  SB_NE      = 0;
   localparam int unsigned  SB_NF      = 1;
   localparam int unsigned  SB_PCM     = 2;
   localparam int unsigned  SB_UNF     = 3;
   localparam int unsigned  SB_OVF     = 4;
   localparam int unsigned  FLAG_W     = 5;
   localparam logic [15:0]  STAT_RESET = 16'h0000;

   // ==========================================================
   // FIFO geometry and level thresholds.
   localparam int unsigned  FIFO_DEPTH    = 8;
   localparam int unsigned  FIFO_AW       = 3;
   localparam logic [3:0]   FIFO_FULL_CNT = 4'h8;
   localparam logic [3:0]   CNT_SAT       = 4'h7;
   localparam logic [3:0]   NF_LEVEL      = 4'h5;
   localparam logic [3:0]   NF_BELOW      = 4'h4;
   localparam logic [3:0]   NE_LEVEL      = 4'h3;
   localparam logic [3:0]   NE_ABOVE      = 4'h4;

   // ==========================================================
   // Sample format of the delta-modulation side.
   typedef enum logic [1:0] {
      FMT_MULAW  = 2'h0,
      FMT_ALAW   = 2'h1,
      FMT_LINEAR = 2'h2,
      FMT_RSVD   = 2'h3
   } cpsc_fmt_t;

endpackage

// *** design/cpsc_fifo.sv ***
// Eight-word FIFO with registered read data and an occupancy count.
`timescale 1ns/100ps
module cpsc_fifo
   import cpsc_pkg::*;
(
   // Clock and reset.
   input  wire logic        sys_clk_i,
   input  wire logic        srst_i,
   input  wire logic        flush_i,
   // Write side.
   input  wire logic        push_i,
   input  wire logic [15:0] wdata_i,
   // Read side.
   input  wire logic        pop_i,
   output logic      [15:0] rdata_o,
   output logic      [3:0]  count_o
);

   logic [15:0]        mem_q [FIFO_DEPTH];
   logic [FIFO_AW-1:0] wp_q;
   logic [FIFO_AW-1:0] rp_q;
   logic               do_push;
   logic               do_pop;

   // A push into a full FIFO and a pop from an empty one are dropped here.
   assign do_push = push_i && (count_o != FIFO_FULL_CNT);
   assign do_pop  = pop_i && (count_o != 4'h0);

   always_ff @(posedge sys_clk_i) begin
      if (do_push) begin
         mem_q[wp_q] <= wdata_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i || flush_i) begin
         wp_q    <= '0;
         rp_q    <= '0;
         count_o <= 4'h0;
      end else begin
         if (do_push) begin
            wp_q <= wp_q + 3'h1;
         end
         if (do_pop) begin
            rp_q <= rp_q + 3'h1;
         end
         count_o <= count_o + {3'h0, do_push} - {3'h0, do_pop};
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         rdata_o <= 16'h0000;
      end else if (do_pop) begin
         rdata_o <= mem_q[rp_q];
      end
   end

endmodule

// *** design/cpsc_top.sv ***
// Control, status, FIFOs and sample buffering of the speech transcoder.
//
// Behaviour
// - PCM input DMA request only when enabled
// - Format field picks mu-law, A-law, linear
// - Companding bit picks mu-law or A-law
// - Attenuation field right-shifts with sign extension
// - Log input expanded left-justified, then shifted
// - Nearly-full sets at three free words
// - Nearly-full raises interrupt and DMA when enabled
// - Status read clears nearly-full
// - Service flag set, read-cleared unless frozen
// - Underflow flag, error interrupt, freeze-protected clear
// - Overflow flag, freeze-protected read clear
// - Overflow raises error interrupt when enabled
// - Status word zero at reset and disabled
// - Input field counts free words, saturated at seven; reads zero once seven or more words are stored
// - Output field counts stored words, saturated
// - Nearly-empty sets at three words, interrupts
// - Nearly-empty raises DMA refill when enabled
// - Status read clears nearly-empty
// - Both FIFOs hold eight 16-bit words
// - Freeze stops core FIFO and PCM output register updates
`timescale 1ns/100ps
module cpsc_top
   import cpsc_pkg::*;
(
   // Clock and reset.
   input  wire logic        sys_clk_i,
   input  wire logic        srst_i,
   // Peripheral bus.
   input  wire logic [7:0]  bus_addr_i,
   input  wire logic        bus_wr_i,
   input  wire logic        bus_rd_i,
   input  wire logic [15:0] bus_wdata_i,
   output logic      [15:0] bus_rdata_o,
   output logic             bus_rvalid_o,
   // Emulator freeze.
   input  wire logic        freeze_i,
   // Converter core.
   input  wire logic        core_cvsd_pop_i,
   output logic      [15:0] core_cvsd_data_o,
   input  wire logic        core_out_push_i,
   input  wire logic [15:0] core_out_data_i,
   output logic             core_pcm_valid_o,
   output logic      [15:0] core_pcm_data_o,
   input  wire logic        core_pcm_ready_i,
   input  wire logic        core_pcm_output_reg_valid_i,
   input  wire logic [15:0] core_pcm_output_reg_data_i,
   output logic             core_clk_en_o,
   output logic      [1:0]  delta_format_select_o,
   output logic             companding_select_o,
   // Interrupt and DMA requests.
   output logic             fifo_level_irq_o,
   output logic             fifo_error_irq_o,
   output logic             pcm_irq_o,
   output logic             pcm_in_dma_req_o,
   output logic             pcm_out_dma_req_o,
   output logic             cvsd_in_dma_req_o,
   output logic             cvsd_out_dma_req_o
);

   // ==========================================================
   // Control register.
   logic [15:0]       ctrl_q;
   logic              en;
   cpsc_fmt_t         fmt;
   logic [1:0]        att;
   logic              wr_ctrl;
   logic              rd_stat;

   assign wr_ctrl = bus_wr_i && (bus_addr_i == ADDR_CTRL);
   assign rd_stat = bus_rd_i && (bus_addr_i == ADDR_STAT);
   assign en      = ctrl_q[CB_ENABLE];
   assign fmt     = cpsc_fmt_t'(ctrl_q[CB_FMT+:2]);
   assign att     = ctrl_q[CB_ATT+:2];

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= bus_wdata_i & CTRL_MASK;
      end
   end

   assign core_clk_en_o         = ctrl_q[CB_CLKEN];
   assign delta_format_select_o = ctrl_q[CB_FMT+:2];
   assign companding_select_o   = ctrl_q[CB_CMP];

   // ==========================================================
   // Delta-modulation FIFOs.
   logic [3:0]        in_cnt;
   logic [3:0]        out_cnt;
   logic [15:0]       out_rdata;
   logic              in_pop;
   logic              out_push;
   logic              rd_cvo;

   // Freeze keeps the core from draining or filling the FIFOs.
   assign in_pop   = core_cvsd_pop_i && !freeze_i && en;
   assign out_push = core_out_push_i && !freeze_i && en;
   assign rd_cvo   = bus_rd_i && (bus_addr_i == ADDR_CVSD_OUT);

   cpsc_fifo u_in_fifo (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .flush_i   (!en),
      .push_i    (bus_wr_i && (bus_addr_i == ADDR_CVSD_IN) && en),
      .wdata_i   (bus_wdata_i),
      .pop_i     (in_pop),
      .rdata_o   (core_cvsd_data_o),
      .count_o   (in_cnt)
   );

   cpsc_fifo u_out_fifo (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .flush_i   (!en),
      .push_i    (out_push),
      .wdata_i   (core_out_data_i),
      .pop_i     (rd_cvo && en),
      .rdata_o   (out_rdata),
      .count_o   (out_cnt)
   );

   // ==========================================================
   // PCM input conditioning.
   // Both law expansions land left-justified in 16 bits, so the low
   // two (mu-law) or three (A-law) bits come out zero.
   function automatic logic [15:0] pcm_cond(input logic [15:0] w,
                                            input cpsc_fmt_t   f,
                                            input logic [1:0]  sh);
      logic [7:0]  x;
      logic [15:0] mag;
      logic [15:0] v;
      x   = 8'h00;
      mag = 16'h0000;
      v   = w;
      if (f == FMT_MULAW) begin
         x   = ~w[7:0];
         mag = ((16'({x[3:0], 3'h0}) + 16'h0084) << x[6:4]) - 16'h0084;
         v   = x[7] ? (16'h0000 - mag) : mag;
      end else if (f == FMT_ALAW) begin
         x   = w[7:0] ^ 8'h55;
         if (x[6:4] == 3'h0) begin
            mag = 16'({x[3:0], 4'h8});
         end else begin
            mag = (16'({x[3:0], 4'h0}) + 16'h0108) << (x[6:4] - 3'h1);
         end
         v   = x[7] ? mag : (16'h0000 - mag);
      end
      return 16'($signed(v) >>> sh);
   endfunction

   // ==========================================================
   // Two-entry PCM input buffer toward the core.
   logic [15:0]       b1_q;
   logic              b1_v_q;
   logic              pcm_push;
   logic              pcm_take;
   logic [15:0]       pcm_word;

   assign pcm_word = pcm_cond(bus_wdata_i, fmt, att);
   // A write that finds both entries taken is dropped; DMA waits on room.
   assign pcm_push = bus_wr_i && (bus_addr_i == ADDR_PCM_IN) && en && !b1_v_q;
   assign pcm_take = core_pcm_valid_o && core_pcm_ready_i;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i || !en) begin
         core_pcm_valid_o <= 1'b0;
         core_pcm_data_o  <= 16'h0000;
         b1_v_q           <= 1'b0;
         b1_q             <= 16'h0000;
      end else if (pcm_push && pcm_take) begin
         if (b1_v_q) begin
            core_pcm_data_o <= b1_q;
            b1_q            <= pcm_word;
         end else begin
            core_pcm_data_o <= pcm_word;
         end
      end else if (pcm_push) begin
         if (!core_pcm_valid_o) begin
            core_pcm_valid_o <= 1'b1;
            core_pcm_data_o  <= pcm_word;
         end else begin
            b1_v_q <= 1'b1;
            b1_q   <= pcm_word;
         end
      end else if (pcm_take) begin
         core_pcm_valid_o <= b1_v_q;
         core_pcm_data_o  <= b1_q;
         b1_v_q           <= 1'b0;
      end
   end

   // ==========================================================
   // PCM output holding register.
   logic [15:0]       pcm_output_reg_q;
   logic              pcm_output_reg_full_q;
   logic              pcm_output_reg_load;

   assign pcm_output_reg_load = core_pcm_output_reg_valid_i && !freeze_i && en;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i || !en) begin
         pcm_output_reg_q      <= 16'h0000;
         pcm_output_reg_full_q <= 1'b0;
      end else if (pcm_output_reg_load) begin
         pcm_output_reg_q      <= core_pcm_output_reg_data_i;
         pcm_output_reg_full_q <= 1'b1;
      end else if (bus_rd_i && (bus_addr_i == ADDR_PCM_OUT)) begin
         pcm_output_reg_full_q <= 1'b0;
      end
   end

   // ==========================================================
   // Status flags.
   logic [3:0]        in_prev_q;
   logic [3:0]        out_prev_q;
   logic [FLAG_W-1:0] flag_q;
   logic [FLAG_W-1:0] set_v;
   logic [FLAG_W-1:0] clr_v;
   logic              nf_evt;
   logic              ne_evt;
   logic              unf_evt;
   logic              ovf_evt;
   logic              pcm_evt;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         in_prev_q  <= 4'h0;
         out_prev_q <= 4'h0;
      end else begin
         in_prev_q  <= in_cnt;
         out_prev_q <= out_cnt;
      end
   end

   // Level flags fire on the crossing, so a read at a steady level
   // does not immediately raise them again.
   assign nf_evt  = en && (out_cnt == NF_LEVEL) && (out_prev_q == NF_BELOW);
   assign ne_evt  = en && (in_cnt == NE_LEVEL) && (in_prev_q == NE_ABOVE);
   assign unf_evt = in_pop && (in_cnt == 4'h0);
   assign ovf_evt = out_push && (out_cnt == FIFO_FULL_CNT);
   assign pcm_evt = pcm_output_reg_load || (pcm_take && b1_v_q);

   assign set_v = {ovf_evt, unf_evt, pcm_evt, nf_evt, ne_evt};
   // Freeze protects only the error and service flags from read clearing.
   assign clr_v = {{3{rd_stat && !freeze_i}}, rd_stat, rd_stat};

   genvar gi;
   for (gi = 0; gi < FLAG_W; gi++) begin : g_flag
      always_ff @(posedge sys_clk_i) begin
         if (srst_i || !en) begin
            flag_q[gi] <= 1'b0;
         end else if (set_v[gi]) begin
            flag_q[gi] <= 1'b1;
         end else if (clr_v[gi]) begin
            flag_q[gi] <= 1'b0;
         end
      end
   end

   logic [2:0]        in_free;
   logic [2:0]        out_fill;
   logic [15:0]       stat_w;

   always_comb begin
      if (in_cnt >= CNT_SAT) begin
         in_free = 3'h0;
      end else if (in_cnt == 4'h0) begin
         in_free = 3'h7;
      end else begin
         in_free = 3'(FIFO_FULL_CNT - in_cnt);
      end
      out_fill = (out_cnt >= CNT_SAT) ? 3'h7 : out_cnt[2:0];
      stat_w   = en ? {5'h00, out_fill, in_free, flag_q} : STAT_RESET;
   end

   // ==========================================================
   // Interrupt and DMA request outputs.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         fifo_level_irq_o   <= 1'b0;
         fifo_error_irq_o   <= 1'b0;
         pcm_irq_o          <= 1'b0;
         pcm_in_dma_req_o   <= 1'b0;
         pcm_out_dma_req_o  <= 1'b0;
         cvsd_in_dma_req_o  <= 1'b0;
         cvsd_out_dma_req_o <= 1'b0;
      end else begin
         fifo_level_irq_o   <= ctrl_q[CB_LVL_IRQ] && (flag_q[SB_NF] || flag_q[SB_NE]);
         fifo_error_irq_o   <= ctrl_q[CB_ERR_IRQ] && (flag_q[SB_OVF] || flag_q[SB_UNF]);
         pcm_irq_o          <= ctrl_q[CB_PCM_IRQ] && flag_q[SB_PCM];
         pcm_in_dma_req_o   <= en && ctrl_q[CB_PCM_IN_DMA] && !b1_v_q;
         pcm_out_dma_req_o  <= en && ctrl_q[CB_PCM_OUT_DMA] && pcm_output_reg_full_q;
         cvsd_in_dma_req_o  <= ctrl_q[CB_CVSD_IN_DMA] && flag_q[SB_NE];
         cvsd_out_dma_req_o <= ctrl_q[CB_CVSD_OUT_DMA] && flag_q[SB_NF];
      end
   end

   // ==========================================================
   // Bus read path: two cycles for every address.
   // The status value is caught in the read cycle, before the clear lands.
   logic [15:0]       rd_mux;
   logic [15:0]       snap_q;
   logic              rd_q;
   logic              rd_out_q;

   always_comb begin
      case (bus_addr_i)
         ADDR_CTRL:    rd_mux = ctrl_q;
         ADDR_STAT:    rd_mux = stat_w;
         ADDR_PCM_OUT: rd_mux = pcm_output_reg_q;
         default:      rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         rd_q     <= 1'b0;
         rd_out_q <= 1'b0;
         snap_q   <= 16'h0000;
      end else begin
         rd_q     <= bus_rd_i;
         rd_out_q <= rd_cvo;
         if (bus_rd_i) begin
            snap_q <= rd_mux;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         bus_rvalid_o <= 1'b0;
         bus_rdata_o  <= 16'h0000;
      end else begin
         bus_rvalid_o <= rd_q;
         if (rd_q) begin
            bus_rdata_o <= rd_out_q ? out_rdata : snap_q;
         end
      end
   end

   // ==========================================================
   // Assertions.
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);

   sequence s_unf_err;
      unf_evt && ctrl_q[CB_ERR_IRQ] && !wr_ctrl;
   endsequence

   sequence s_ovf_err;
      ovf_evt && ctrl_q[CB_ERR_IRQ] && !wr_ctrl;
   endsequence

   pcm_dma_gate_a: assert property (pcm_in_dma_req_o |-> $past(ctrl_q[CB_PCM_IN_DMA]))
      else $error("PCM input DMA request without its enable.");

   linear_shift_a: assert property ((pcm_push && !core_pcm_valid_o && fmt == FMT_LINEAR)
      |=> $signed(core_pcm_data_o) == ($signed($past(bus_wdata_i)) >>> $past(att)))
      else $error("Linear sample not shifted by the attenuation field.");

   log_justify_a: assert property ((pcm_push && !core_pcm_valid_o && att == 2'h0
      && fmt == FMT_ALAW) |=> core_pcm_data_o[2:0] == 3'h0)
      else $error("A-law sample not left-justified.");

   nf_raise_a: assert property ((en && out_cnt == NF_LEVEL && out_prev_q == NF_BELOW
      && !wr_ctrl) |=> flag_q[SB_NF] ##1 (cvsd_out_dma_req_o == ctrl_q[CB_CVSD_OUT_DMA]))
      else $error("Nearly-full flag or its DMA request missing.");

   nf_clear_a: assert property ((rd_stat && en && !nf_evt && !wr_ctrl) |=> !flag_q[SB_NF])
      else $error("Status read did not clear nearly-full.");

   frz_hold_a: assert property ((freeze_i && en && !wr_ctrl) ##0 flag_q[SB_PCM]
      |=> flag_q[SB_PCM])
      else $error("Service flag cleared during freeze.");

   unf_irq_a: assert property (s_unf_err |=> flag_q[SB_UNF] ##1 fifo_error_irq_o)
      else $error("Underflow did not raise the error request.");

   ovf_irq_a: assert property (s_ovf_err |=> flag_q[SB_OVF] ##1 fifo_error_irq_o)
      else $error("Overflow did not raise the error request.");

   stat_off_a: assert property ((rd_stat && !en) |=> ##1 (bus_rvalid_o && bus_rdata_o == 16'h0000))
      else $error("Status word not zero while disabled.");

   free_field_a: assert property ((rd_stat && en && in_cnt == 4'h0)
      |=> ##1 bus_rdata_o[7:5] == 3'h7)
      else $error("Input free field wrong when empty.");

   fill_field_a: assert property ((rd_stat && en && out_cnt == FIFO_FULL_CNT)
      |=> ##1 bus_rdata_o[10:8] == 3'h7)
      else $error("Output fill field wrong when full.");

   frz_fifo_a: assert property (freeze_i |=> out_cnt <= $past(out_cnt))
      else $error("Output FIFO grew during freeze.");

endmodule

// *** test/cpsc_host_model.sv ***
// Processor model that reaches the converter registers over the peripheral bus.
`timescale 1ns/100ps
module cpsc_host_model (
   // Clock.
   input  wire logic        sys_clk_i,
   // Peripheral bus.
   output logic      [7:0]  bus_addr_o,
   output logic             bus_wr_o,
   output logic             bus_rd_o,
   output logic      [15:0] bus_wdata_o,
   input  wire logic [15:0] bus_rdata_i,
   input  wire logic        bus_rvalid_i
);
   initial begin
      bus_addr_o = 8'h00;
      bus_wr_o = 1'b0;
      bus_rd_o = 1'b0;
      bus_wdata_o = 16'h0000;
   end

   // ==========================================================
   // Bus cycles.
   // Released lines show the inverse of the last value, so stale data never looks valid.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge sys_clk_i);
      bus_addr_o = a;
      bus_wdata_o = d;
      bus_wr_o = 1'b1;
      @(negedge sys_clk_i);
      bus_wr_o = 1'b0;
      bus_addr_o = ~a;
      bus_wdata_o = ~d;
   endtask

   // The fill count field, never the level flag, tells the reader how much to fetch.
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      logic ok;
      ok = 1'b0;
      d = 16'hXXXX;
      @(negedge sys_clk_i);
      bus_addr_o = a;
      bus_rd_o = 1'b1;
      @(negedge sys_clk_i);
      bus_rd_o = 1'b0;
      bus_addr_o = ~a;
      repeat (3) begin
         @(negedge sys_clk_i);
         if (!ok && bus_rvalid_i === 1'b1) begin
            ok = 1'b1;
            d = bus_rdata_i;
         end
      end
   endtask
endmodule

// *** test/cvsd_pcm_status_control_bench.sv ***
// Self-checking testbench of the converter control and status block.
`timescale 1ns/100ps
module cvsd_pcm_status_control_bench;
   import cpsc_pkg::*;
   logic        sys_clk_i, srst_i, freeze_i;
   logic [7:0]  bus_addr_i;
   logic        bus_wr_i, bus_rd_i, bus_rvalid_o;
   logic [15:0] bus_wdata_i, bus_rdata_o, core_cvsd_data_o, core_out_data_i, core_pcm_data_o;
   logic        core_cvsd_pop_i, core_out_push_i, core_pcm_valid_o, core_pcm_ready_i;
   logic        core_pcm_output_reg_valid_i;
   logic [15:0] core_pcm_output_reg_data_i;
   logic        core_clk_en_o, companding_select_o, fifo_level_irq_o, fifo_error_irq_o;
   logic        pcm_irq_o, pcm_in_dma_req_o, pcm_out_dma_req_o;
   logic        cvsd_in_dma_req_o, cvsd_out_dma_req_o;
   logic [1:0]  delta_format_select_o;
   logic [15:0] v;
   int          n_fail, check_count;

   cpsc_top dut_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .bus_addr_i(bus_addr_i),
      .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i),
      .bus_rdata_o(bus_rdata_o), .bus_rvalid_o(bus_rvalid_o), .freeze_i(freeze_i),
      .core_cvsd_pop_i(core_cvsd_pop_i), .core_cvsd_data_o(core_cvsd_data_o),
      .core_out_push_i(core_out_push_i), .core_out_data_i(core_out_data_i),
      .core_pcm_valid_o(core_pcm_valid_o), .core_pcm_data_o(core_pcm_data_o),
      .core_pcm_ready_i(core_pcm_ready_i), .core_pcm_output_reg_valid_i(core_pcm_output_reg_valid_i),
      .core_pcm_output_reg_data_i(core_pcm_output_reg_data_i), .core_clk_en_o(core_clk_en_o),
      .delta_format_select_o(delta_format_select_o),
      .companding_select_o(companding_select_o), .fifo_level_irq_o(fifo_level_irq_o),
      .fifo_error_irq_o(fifo_error_irq_o), .pcm_irq_o(pcm_irq_o),
      .pcm_in_dma_req_o(pcm_in_dma_req_o), .pcm_out_dma_req_o(pcm_out_dma_req_o),
      .cvsd_in_dma_req_o(cvsd_in_dma_req_o), .cvsd_out_dma_req_o(cvsd_out_dma_req_o));

   cpsc_host_model host_u (.sys_clk_i(sys_clk_i), .bus_addr_o(bus_addr_i),
      .bus_wr_o(bus_wr_i), .bus_rd_o(bus_rd_i), .bus_wdata_o(bus_wdata_i),
      .bus_rdata_i(bus_rdata_o), .bus_rvalid_i(bus_rvalid_o));

   // ==========================================================
   // Checking and closing.
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ==========================================================
   // Core side drivers, one pulse per cycle back to back.
   task automatic pop(input int n);
      repeat (n) begin
         @(negedge sys_clk_i);
         core_cvsd_pop_i = 1'b1;
      end
      @(negedge sys_clk_i);
      core_cvsd_pop_i = 1'b0;
   endtask

   task automatic push(input int n, input logic [15:0] b);
      for (int i = 0; i < n; i++) begin
         @(negedge sys_clk_i);
         core_out_push_i = 1'b1;
         core_out_data_i = b + 16'(i);
      end
      @(negedge sys_clk_i);
      core_out_push_i = 1'b0;
   endtask

   task automatic take();
      @(negedge sys_clk_i);
      core_pcm_ready_i = 1'b1;
      @(negedge sys_clk_i);
      core_pcm_ready_i = 1'b0;
   endtask

   task automatic sts(input logic [15:0] e);
      host_u.rd(ADDR_STAT, v);
      chk("status", v, e);
   endtask

   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   initial begin
      #100000;
      n_fail++;
      test_done();
   end

   initial begin
      srst_i = 1'b1;
      freeze_i = 1'b0;
      core_cvsd_pop_i = 1'b0;
      core_out_push_i = 1'b0;
      core_out_data_i = 16'h0000;
      core_pcm_ready_i = 1'b0;
      core_pcm_output_reg_valid_i = 1'b0;
      core_pcm_output_reg_data_i = 16'h0000;
      n_fail = 0;
      check_count = 0;
      repeat (12) @(negedge sys_clk_i);
      srst_i = 1'b0;
      host_u.rd(ADDR_CTRL, v);
      chk("control", v, CTRL_RESET);
      sts(STAT_RESET);
      host_u.rd(8'h40, v);
      chk("unmapped", v, 16'h0000);
      $display("test reset done");

      // Input FIFO: nearly-empty on the 4 to 3 step, then underflow.
      host_u.wr(ADDR_CTRL, 16'h00DD);
      sts(16'h00E0);
      for (int i = 1; i <= 5; i++)
         host_u.wr(ADDR_CVSD_IN, 16'(i * 16'h1111));
      pop(2);
      chk("popped", core_cvsd_data_o, 16'h2222);
      repeat (2) @(negedge sys_clk_i);
      chk("level irq", 16'(fifo_level_irq_o), 16'h0001);
      chk("in dma", 16'(cvsd_in_dma_req_o), 16'h0001);
      sts(16'h00A1);
      sts(16'h00A0);
      pop(4);
      @(negedge sys_clk_i);
      chk("error irq", 16'(fifo_error_irq_o), 16'h0001);
      @(negedge sys_clk_i);
      freeze_i = 1'b1;
      sts(16'h00E8);
      sts(16'h00E8);
      freeze_i = 1'b0;
      sts(16'h00E8);
      sts(16'h00E0);
      $display("test input fifo done");

      // Output FIFO: nearly-full on the 4 to 5 step, then overflow.
      push(5, 16'hA000);
      repeat (2) @(negedge sys_clk_i);
      chk("out dma", 16'(cvsd_out_dma_req_o), 16'h0001);
      sts(16'h05E2);
      push(4, 16'hA005);
      @(negedge sys_clk_i);
      chk("error irq", 16'(fifo_error_irq_o), 16'h0001);
      sts(16'h07F0);
      host_u.rd(ADDR_CVSD_OUT, v);
      chk("out word", v, 16'hA000);
      sts(16'h07E0);
      $display("test output fifo done");

      // PCM input buffer with linear format and two bits of attenuation.
      host_u.wr(ADDR_CTRL, 16'h49DD);
      @(negedge sys_clk_i);
      chk("pcm dma", 16'(pcm_in_dma_req_o), 16'h0001);
      host_u.wr(ADDR_PCM_IN, 16'h8000);
      chk("pcm head", core_pcm_data_o, 16'hE000);
      host_u.wr(ADDR_PCM_IN, 16'h1234);
      host_u.wr(ADDR_PCM_IN, 16'h5678);
      chk("pcm dma full", 16'(pcm_in_dma_req_o), 16'h0000);
      take();
      chk("pcm head", core_pcm_data_o, 16'h048D);
      @(negedge sys_clk_i);
      chk("pcm irq", 16'(pcm_irq_o), 16'h0001);
      take();
      chk("pcm valid", 16'(core_pcm_valid_o), 16'h0000);
      freeze_i = 1'b1;
      sts(16'h07E4);
      freeze_i = 1'b0;
      sts(16'h07E4);
      sts(16'h07E0);
      $display("test pcm buffer done");

      // Format codes, companding select and log expansion.
      for (int f = 0; f < 4; f++) begin
         host_u.wr(ADDR_CTRL, 16'h0001 | 16'(f << CB_FMT));
         chk("format", 16'(delta_format_select_o), 16'(f));
      end
      host_u.wr(ADDR_CTRL, 16'h1001);
      chk("companding", 16'(companding_select_o), 16'h0001);
      host_u.wr(ADDR_CTRL, 16'h0001);
      chk("companding", 16'(companding_select_o), 16'h0000);
      host_u.wr(ADDR_PCM_IN, 16'hAB80);
      chk("log head", core_pcm_data_o, 16'h7D7C);
      take();
      host_u.wr(ADDR_CTRL, 16'h2001);
      host_u.wr(ADDR_PCM_IN, 16'hAB80);
      chk("log head", core_pcm_data_o, 16'h3EBE);
      take();
      host_u.wr(ADDR_CTRL, 16'h0401);
      host_u.wr(ADDR_PCM_IN, 16'h00AA);
      chk("alaw head", core_pcm_data_o, 16'h7E00);
      // A core load during freeze must leave the output register alone.
      host_u.wr(ADDR_CTRL, 16'h0023);
      chk("clock enable", 16'(core_clk_en_o), 16'h0001);
      freeze_i = 1'b1;
      core_pcm_output_reg_valid_i = 1'b1;
      core_pcm_output_reg_data_i = 16'h5A5A;
      @(negedge sys_clk_i);
      freeze_i = 1'b0;
      core_pcm_output_reg_valid_i = 1'b0;
      host_u.rd(ADDR_PCM_OUT, v);
      chk("frozen pcm out", v, 16'h0000);
      core_pcm_output_reg_valid_i = 1'b1;
      @(negedge sys_clk_i);
      core_pcm_output_reg_valid_i = 1'b0;
      @(negedge sys_clk_i);
      chk("pcm out dma", 16'(pcm_out_dma_req_o), 16'h0001);
      host_u.rd(ADDR_PCM_OUT, v);
      chk("pcm out", v, 16'h5A5A);
      sts(16'h07E4);
      host_u.wr(ADDR_CTRL, 16'h0000);
      sts(STAT_RESET);
      $display("test formats done");
      test_done();
   end
endmodule
